// *** src/adcseq_ctrl.sv ***
// ADC reading sequencer control: registers, program arbitration and slot sequencing.
`timescale 1ns/1ps
module adcseq_ctrl #(
	parameter int DLY_TICK_CYCLES = 250
) (
	input  wire logic                        core_clk,
	input  wire logic                        sys_rst,
	input  wire logic                        digital_reset_n,
	input  wire logic                        reg_wr_en,
	input  wire logic                        reg_rd_en,
	input  wire logic [adcseq_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [adcseq_pkg::REG_W-1:0]  reg_wdata,
	output logic      [adcseq_pkg::REG_W-1:0]  reg_rdata,
	output logic                             reg_rd_valid,
	output logic                             gp_conv_enable,
	output logic                             touch_enable,
	output logic                             pen_detect_enable,
	output logic                             manual_led_ctrl_en,
	output adcseq_pkg::adcseq_conv_req_type  conv_req,
	input  adcseq_pkg::adcseq_conv_rsp_type  conv_rsp
);
	import adcseq_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE, S_PRE, S_CONV, S_WAIT, S_STORE, S_INTER, S_POST
	} adcseq_state_type;

	function automatic logic [3:0] nib(input logic [31:0] v, input logic [2:0] i);
		nib = v[{i, 2'h0} +: NIB_W];
	endfunction

	// ----------------------------------------------------------------
	// Reset synchroniser
	// ----------------------------------------------------------------
	logic dr_meta_reg;
	logic dr_sync_reg;
	logic rst_int;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			dr_meta_reg <= 1'b0;
			dr_sync_reg <= 1'b0;
		end else begin
			dr_meta_reg <= digital_reset_n;
			dr_sync_reg <= dr_meta_reg;
		end
	end

	assign rst_int = sys_rst | ~dr_sync_reg;

	// ----------------------------------------------------------------
	// Register storage and decode
	// ----------------------------------------------------------------
	adcseq_state_type    state_reg, state_next;
	logic [REG_W-1:0]    ctrl_reg, dly_reg, sel_lo_reg, sel_hi_reg;
	logic [RES_W-1:0]    result_mem [N_SLOTS];
	logic [2:0]          slot_reg, slot_next;
	logic                run_touch_reg, run_touch_next;
	logic [3:0]          dly_cnt_reg, dly_cnt_next;
	logic [RES_W-1:0]    cap_reg;
	logic [15:0]         tick_cnt_reg;
	logic                tick;
	logic                wr_ctrl, wr_dly, wr_sel_lo, wr_sel_hi;
	logic                gp_go, ts_go, take_gp, take_ts, hold_all;
	logic                act_cont, act_en, last_slot, dly_done, do_store;
	logic [2:0]          act_stop;
	logic [31:0]         sel_all;
	logic [2:0]          res_idx;
	logic [REG_W-1:0]    rd_mux, res_word;
	logic                issue;

	assign wr_ctrl   = reg_wr_en && (reg_addr == ADDR_CTRL);
	assign wr_dly    = reg_wr_en && (reg_addr == ADDR_DLY);
	assign wr_sel_lo = reg_wr_en && (reg_addr == ADDR_SEL_LO);
	assign wr_sel_hi = reg_wr_en && (reg_addr == ADDR_SEL_HI);
	assign sel_all   = {sel_hi_reg[SEL_HI_W-1:0], sel_lo_reg};

	assign res_idx  = 3'((reg_addr - ADDR_RES0) << 1);
	assign res_word = {result_mem[res_idx + 3'h1], 2'h0, result_mem[res_idx], 2'h0};
	assign rd_mux   = (reg_addr == ADDR_CTRL)   ? ctrl_reg :
	                  (reg_addr == ADDR_DLY)    ? dly_reg :
	                  (reg_addr == ADDR_SEL_LO) ? sel_lo_reg :
	                  (reg_addr == ADDR_SEL_HI) ? sel_hi_reg :
	                  (reg_addr >= ADDR_RES0 && reg_addr <= ADDR_RES3) ? res_word :
	                  REG_RESET;

	// A host write overrides the hardware clear, so a new request is never lost.
	always_ff @(posedge core_clk) begin
		if (rst_int) begin
			ctrl_reg   <= REG_RESET;
			dly_reg    <= REG_RESET;
			sel_lo_reg <= REG_RESET;
			sel_hi_reg <= REG_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= reg_wdata;
			end else begin
				ctrl_reg[B_GP_START] <= ctrl_reg[B_GP_START] & ~take_gp;
				ctrl_reg[B_TS_START] <= ctrl_reg[B_TS_START] & ~take_ts;
			end
			if (wr_dly) begin
				dly_reg <= reg_wdata;
			end
			if (wr_sel_lo) begin
				sel_lo_reg <= reg_wdata;
			end
			if (wr_sel_hi) begin
				sel_hi_reg <= reg_wdata;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst_int) begin
			reg_rdata    <= REG_RESET;
			reg_rd_valid <= 1'b0;
		end else begin
			reg_rdata    <= reg_rd_en ? rd_mux : REG_RESET;
			reg_rd_valid <= reg_rd_en;
		end
	end

	assign gp_conv_enable     = ctrl_reg[B_GP_EN];
	assign manual_led_ctrl_en = ctrl_reg[B_LED_MAN];
	assign touch_enable       = ctrl_reg[B_TS_EN];
	assign pen_detect_enable  = ctrl_reg[B_PEN_EN];

	// ----------------------------------------------------------------
	// Delay tick divider
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst_int || tick) begin
			tick_cnt_reg <= 16'h0000;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 16'h0001;
		end
	end

	assign tick = (tick_cnt_reg == 16'(DLY_TICK_CYCLES - 1));

	// ----------------------------------------------------------------
	// Program arbitration and sequencing
	// ----------------------------------------------------------------
	assign ts_go    = ctrl_reg[B_TS_START] && ctrl_reg[B_TS_EN];
	assign gp_go    = ctrl_reg[B_GP_START] && ctrl_reg[B_GP_EN];
	assign take_ts  = (state_reg == S_IDLE) && ts_go;
	assign take_gp  = (state_reg == S_IDLE) && gp_go && !ts_go;
	assign hold_all = ctrl_reg[B_GP_HOLD] | ctrl_reg[B_TS_HOLD];
	assign act_cont = run_touch_reg ? ctrl_reg[B_TS_CONT] : ctrl_reg[B_GP_CONT];
	assign act_en   = run_touch_reg ? ctrl_reg[B_TS_EN] : ctrl_reg[B_GP_EN];
	assign act_stop = run_touch_reg ? ctrl_reg[B_TS_STOP +: STOP_W] :
	                  ctrl_reg[B_GP_STOP +: STOP_W];
	assign last_slot = (slot_reg == act_stop);
	assign dly_done  = (dly_cnt_reg == 4'h0) && !hold_all;
	assign do_store  = (state_reg == S_STORE) && !hold_all;
	assign issue     = (state_reg == S_CONV) && !hold_all;

	always_comb begin
		state_next     = state_reg;
		slot_next      = slot_reg;
		run_touch_next = run_touch_reg;
		dly_cnt_next   = (tick && !hold_all && dly_cnt_reg != 4'h0) ?
		                 dly_cnt_reg - 4'h1 : dly_cnt_reg;
		case (state_reg)
			S_IDLE: begin
				if (take_ts) begin
					run_touch_next = 1'b1;
					slot_next      = 3'h0;
					dly_cnt_next   = nib({8'h00, dly_reg}, 3'(N_TS_PRE));
					state_next     = S_PRE;
				end else if (take_gp) begin
					run_touch_next = 1'b0;
					slot_next      = 3'h0;
					dly_cnt_next   = nib({8'h00, dly_reg}, 3'(N_GP_PRE));
					state_next     = S_PRE;
				end
			end
			S_PRE, S_INTER, S_POST: begin
				if (dly_done) begin
					state_next = S_CONV;
				end
			end
			S_CONV: begin
				if (issue) begin
					state_next = S_WAIT;
				end
			end
			S_WAIT: begin
				if (conv_rsp.done) begin
					state_next = S_STORE;
				end
			end
			S_STORE: begin
				if (do_store && last_slot && act_cont) begin
					slot_next    = 3'h0;
					dly_cnt_next = nib({8'h00, dly_reg},
					               run_touch_reg ? 3'(N_TS_POST) : 3'(N_GP_POST));
					state_next   = S_POST;
				end else if (do_store && last_slot) begin
					state_next = S_IDLE;
				end else if (do_store) begin
					slot_next    = slot_reg + 3'h1;
					dly_cnt_next = nib({8'h00, dly_reg},
					               run_touch_reg ? 3'(N_TS_INTER) : 3'(N_GP_INTER));
					state_next   = S_INTER;
				end
			end
			default: begin
				state_next = S_IDLE;
			end
		endcase
		if (state_reg != S_IDLE && !act_en) begin
			state_next = S_IDLE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst_int) begin
			state_reg     <= S_IDLE;
			slot_reg      <= 3'h0;
			run_touch_reg <= 1'b0;
			dly_cnt_reg   <= 4'h0;
		end else begin
			state_reg     <= state_next;
			slot_reg      <= slot_next;
			run_touch_reg <= run_touch_next;
			dly_cnt_reg   <= dly_cnt_next;
		end
	end

	// ----------------------------------------------------------------
	// Converter request and result capture
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst_int) begin
			conv_req <= '0;
			cap_reg  <= '0;
		end else begin
			conv_req.start <= issue;
			if (issue) begin
				conv_req.touch   <= run_touch_reg;
				conv_req.channel <= nib(sel_all, slot_reg);
				conv_req.action  <= sel_hi_reg[ACT_LSB + {slot_reg, 1'b0} +: ACT_W];
			end
			if (state_reg == S_WAIT && conv_rsp.done) begin
				cap_reg <= conv_rsp.data;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst_int) begin
			for (int i = 0; i < N_SLOTS; i++) begin
				result_mem[i] <= '0;
			end
		end else if (do_store) begin
			result_mem[slot_reg] <= cap_reg;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst_int);

	a_touch_first_wins: assert property ((state_reg == S_IDLE) && ts_go && gp_go
		|=> run_touch_reg && (state_reg == S_PRE) && ctrl_reg[B_GP_START])
		else $error("touch request not served first");
	a_gp_start_taken: assert property (take_gp && !wr_ctrl
		|=> !ctrl_reg[B_GP_START] && !run_touch_reg)
		else $error("general request not taken");
	a_hold_no_issue: assert property (conv_req.start |-> $past(!hold_all))
		else $error("conversion issued during hold");
	a_hold_freeze_store: assert property ((state_reg == S_STORE) && hold_all
		&& act_en |=> (state_reg == S_STORE) && $stable(slot_reg))
		else $error("sequencer advanced during hold");
	a_slot_ascends: assert property (do_store && !last_slot && act_en
		|=> slot_reg == $past(slot_reg) + 3'h1)
		else $error("slot did not ascend");
	a_stop_once_end: assert property (do_store && last_slot && !act_cont && act_en
		|=> state_reg == S_IDLE)
		else $error("one-shot run did not finish");
	a_cont_wraps_zero: assert property (do_store && last_slot && act_cont && act_en
		|=> slot_reg == 3'h0 && state_reg == S_POST)
		else $error("continuous run did not wrap");
	a_result_written: assert property (do_store
		|=> result_mem[$past(slot_reg)] == $past(cap_reg))
		else $error("result not stored in slot");
	a_chan_selected: assert property (issue
		|=> conv_req.start && conv_req.channel == $past(nib(sel_all, slot_reg)))
		else $error("wrong channel sent");
	a_pre_delay_hold: assert property ((state_reg == S_PRE) && dly_cnt_reg != 4'h0
		&& act_en |=> state_reg == S_PRE)
		else $error("pre delay skipped");
	a_start_then_wait: assert property (conv_req.start && act_en
		|-> state_reg == S_WAIT ##1 !conv_req.start)
		else $error("start pulse not single");
	a_inter_delay_hold: assert property ((state_reg == S_INTER) && dly_cnt_reg != 4'h0
		&& act_en |=> state_reg == S_INTER)
		else $error("inter delay skipped");
	a_post_delay_hold: assert property ((state_reg == S_POST) && dly_cnt_reg != 4'h0
		&& act_en |=> state_reg == S_POST)
		else $error("post delay skipped");
	a_touch_action_sent: assert property (issue && run_touch_reg
		|=> conv_req.touch && conv_req.action == $past(sel_hi_reg[ACT_LSB + {slot_reg, 1'b0} +: ACT_W]))
		else $error("wrong touch action sent");
	a_read_answered: assert property (reg_rd_en |=> reg_rd_valid)
		else $error("read not answered");

	c_gp_one_shot: cover property (take_gp ##[1:200] (do_store && last_slot && !act_cont));
	c_touch_run: cover property (take_ts ##[1:200] do_store);
	c_wrap: cover property (do_store && last_slot && act_cont);
	c_hold_pause: cover property ((state_reg == S_STORE) && hold_all);
	c_touch_wrap: cover property (do_store && last_slot && act_cont && run_touch_reg);

endmodule

// *** src/adcseq_pkg.sv ***
// Constants and types shared by the ADC reading sequencer control block.
package adcseq_pkg;

	// ----------------------------------------------------------------
	// Register addresses and widths
	// ----------------------------------------------------------------
	localparam int          REG_W        = 24;
	localparam int          ADDR_W       = 6;
	localparam logic [5:0]  ADDR_CTRL    = 6'h2B;
	localparam logic [5:0]  ADDR_DLY     = 6'h2C;
	localparam logic [5:0]  ADDR_SEL_LO  = 6'h2D;
	localparam logic [5:0]  ADDR_SEL_HI  = 6'h2E;
	localparam logic [5:0]  ADDR_RES0    = 6'h2F;
	localparam logic [5:0]  ADDR_RES3    = 6'h32;
	localparam logic [23:0] REG_RESET    = 24'h000000;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int B_GP_EN      = 0;
	localparam int B_GP_START   = 1;
	localparam int B_GP_CONT    = 2;
	localparam int B_GP_HOLD    = 3;
	localparam int B_GP_STOP    = 4;
	localparam int B_LED_MAN    = 8;
	localparam int B_TS_EN      = 12;
	localparam int B_TS_START   = 13;
	localparam int B_TS_CONT    = 14;
	localparam int B_TS_HOLD    = 15;
	localparam int B_TS_STOP    = 16;
	localparam int B_PEN_EN     = 20;
	localparam int STOP_W       = 3;

	// ----------------------------------------------------------------
	// Delay, channel-select, action and result fields
	// ----------------------------------------------------------------
	localparam int N_GP_PRE     = 0;
	localparam int N_GP_INTER   = 1;
	localparam int N_GP_POST    = 2;
	localparam int N_TS_PRE     = 3;
	localparam int N_TS_INTER   = 4;
	localparam int N_TS_POST    = 5;
	localparam int SEL_HI_W     = 8;
	localparam int ACT_LSB      = 8;
	localparam int ACT_W        = 2;
	localparam int NIB_W        = 4;
	localparam int RES_W        = 10;
	localparam int RES_LO_LSB   = 2;
	localparam int RES_HI_LSB   = 14;
	localparam int N_SLOTS      = 8;

	// ----------------------------------------------------------------
	// Converter request and answer
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       start;
		logic       touch;
		logic [1:0] action;
		logic [3:0] channel;
	} adcseq_conv_req_type;

	typedef struct packed {
		logic       done;
		logic [9:0] data;
	} adcseq_conv_rsp_type;

	typedef enum logic [1:0] {
		ACT_DUMMY   = 2'h0,
		ACT_XPLATE  = 2'h1,
		ACT_YPLATE  = 2'h2,
		ACT_CONTACT = 2'h3
	} adcseq_action_type;

endpackage

// *** tb/adcseq_conv_model.sv ***
// Behavioural model of the analog converter behind the sequencer.
`timescale 1ns/1ps
module adcseq_conv_model #(
	parameter int LAT = 4
) (
	input  wire logic                       core_clk,
	input  wire logic                       sys_rst,
	input  wire logic                       slow,
	input  adcseq_pkg::adcseq_conv_req_type conv_req,
	output adcseq_pkg::adcseq_conv_rsp_type conv_rsp
);
	import adcseq_pkg::*;
	int         cnt;
	logic [9:0] pend;
	// A result encodes the request; between answers the data lines toggle.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cnt      <= 0;
			conv_rsp <= '0;
		end else begin
			conv_rsp.done <= 1'b0;
			if (!conv_rsp.done) conv_rsp.data <= ~conv_rsp.data;
			if (conv_req.start) begin
				cnt  <= slow ? 3 * LAT : LAT;
				pend <= {conv_req.touch, conv_req.touch ? conv_req.action : 2'h0, 3'h5,
					conv_req.channel};
			end else if (cnt == 1) begin
				conv_rsp <= {1'b1, pend};
				cnt      <= 0;
			end else if (cnt > 1) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule

// *** tb/test_adcseq_ctrl.sv ***
// Self-checking bench for the ADC reading sequencer control block.
`timescale 1ns/1ps
module test_adcseq_ctrl;
	import adcseq_pkg::*;
	typedef struct {
		logic [5:0]  a;
		logic [23:0] w;
		logic        wr;
		logic [23:0] e;
	} adcseq_row_type;
	logic                core_clk        = 1'b0;
	logic                sys_rst         = 1'b1;
	logic                digital_reset_n = 1'b1;
	logic                reg_wr_en       = 1'b0;
	logic                reg_rd_en       = 1'b0;
	logic [5:0]          reg_addr        = 6'h00;
	logic [23:0]         reg_wdata       = 24'h000000;
	logic                slow            = 1'b0;
	logic [23:0]         reg_rdata;
	logic                reg_rd_valid;
	logic                gp_conv_enable;
	logic                touch_enable;
	logic                pen_detect_enable;
	logic                manual_led_ctrl_en;
	adcseq_conv_req_type conv_req;
	adcseq_conv_rsp_type conv_rsp;
	adcseq_conv_req_type seen[$];
	int                  mismatches = 0;
	int                  n_tests = 0;
	int                  cycles = 0;
	int                  t0;
	int                  hb[2] = '{3, 15};
	adcseq_row_type rows[11] = '{
		'{6'h2B, 24'h000000, 1'b0, 24'h000000}, '{6'h2C, 24'h000000, 1'b0, 24'h000000},
		'{6'h2D, 24'h000000, 1'b0, 24'h000000}, '{6'h2E, 24'h000000, 1'b0, 24'h000000},
		'{6'h2F, 24'h000000, 1'b0, 24'h000000}, '{6'h2C, 24'hABCDEF, 1'b1, 24'hABCDEF},
		'{6'h2D, 24'h123456, 1'b1, 24'h123456}, '{6'h2E, 24'hFEDCBA, 1'b1, 24'hFEDCBA},
		'{6'h2A, 24'h555555, 1'b1, 24'h000000}, '{6'h2F, 24'hFFFFFF, 1'b1, 24'h000000},
		'{6'h2B, 24'h100100, 1'b1, 24'h100100}};

	adcseq_ctrl #(.DLY_TICK_CYCLES(2)) u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.digital_reset_n(digital_reset_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rd_valid(reg_rd_valid), .gp_conv_enable(gp_conv_enable),
		.touch_enable(touch_enable), .pen_detect_enable(pen_detect_enable),
		.manual_led_ctrl_en(manual_led_ctrl_en), .conv_req(conv_req), .conv_rsp(conv_rsp));
	adcseq_conv_model #(.LAT(4)) u_conv (.core_clk(core_clk), .sys_rst(sys_rst),
		.slow(slow), .conv_req(conv_req), .conv_rsp(conv_rsp));

	always #2 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (sys_rst === 1'b0 && conv_req.start === 1'b1) seen.push_back(conv_req);
		if (cycles == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	task automatic check_word(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_bit(input logic got, input logic exp);
		check_word({23'h0, got}, {23'h0, exp});
	endtask
	task automatic reg_write(input logic [5:0] a, input logic [23:0] d);
		@(posedge core_clk);
		#1 reg_wr_en = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge core_clk);
		#1 reg_wr_en = 1'b0;
	endtask
	task automatic read_check(input logic [5:0] a, input logic [23:0] exp);
		@(posedge core_clk);
		#1 reg_rd_en = 1'b1;
		reg_addr = a;
		@(posedge core_clk);
		#1 reg_rd_en = 1'b0;
		check_bit(reg_rd_valid, 1'b1);
		check_word(reg_rdata, exp);
	endtask
	task automatic wait_starts(input int n);
		int k;
		for (k = 0; k < 2000 && seen.size() < n; k++) @(posedge core_clk);
		check_bit(seen.size() >= n, 1'b1);
	endtask
	task automatic tally_and_finish;
		if (mismatches == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge core_clk);
		#1 sys_rst = 1'b0;
		repeat (3) @(posedge core_clk);
		for (int i = 0; i < 11; i++) begin
			if (rows[i].wr) reg_write(rows[i].a, rows[i].w);
			read_check(rows[i].a, rows[i].e);
		end
		check_bit(manual_led_ctrl_en, 1'b1);
		check_bit(pen_detect_enable, 1'b1);
		check_bit(touch_enable, 1'b0);
		reg_write(ADDR_DLY, 24'h000000);
		reg_write(ADDR_SEL_LO, 24'h654321);
		seen.delete();
		reg_write(ADDR_CTRL, 24'h000023);
		check_bit(gp_conv_enable, 1'b1);
		wait_starts(3);
		repeat (30) @(posedge core_clk);
		check_word(24'(seen.size()), 24'h000003);
		for (int i = 0; i < 3; i++)
			check_word({19'h0, seen[i].touch, seen[i].channel}, {19'h0, 1'b0, 4'(i + 1)});
		read_check(ADDR_CTRL, 24'h000021);
		read_check(ADDR_RES0, {10'h052, 2'h0, 10'h051, 2'h0});
		read_check(6'h30, {10'h000, 2'h0, 10'h053, 2'h0});
		reg_write(ADDR_SEL_HI, 24'h00E487);
		seen.delete();
		reg_write(ADDR_CTRL, 24'h033003);
		check_bit(touch_enable, 1'b1);
		wait_starts(5);
		for (int i = 0; i < 4; i++)
			check_word({21'h0, seen[i].touch, seen[i].action}, {21'h0, 1'b1, 2'(i)});
		check_word({19'h0, seen[4].touch, seen[4].channel}, {19'h0, 1'b0, 4'h1});
		repeat (30) @(posedge core_clk);
		for (int j = 0; j < 2; j++) begin
			seen.delete();
			reg_write(ADDR_CTRL, 24'h000003 | (24'h000001 << hb[j]));
			repeat (40) @(posedge core_clk);
			check_word(24'(seen.size()), 24'h000000);
			reg_write(ADDR_CTRL, 24'h000001);
			wait_starts(1);
			repeat (30) @(posedge core_clk);
		end
		reg_write(ADDR_DLY, 24'h00000F);
		seen.delete();
		t0 = cycles;
		reg_write(ADDR_CTRL, 24'h000003);
		wait_starts(1);
		check_bit((cycles - t0) >= 29 && (cycles - t0) <= 40, 1'b1);
		repeat (30) @(posedge core_clk);
		seen.delete();
		reg_write(ADDR_CTRL, 24'h007000);
		wait_starts(3);
		check_word({23'h0, seen[2].touch}, 24'h000001);
		reg_write(ADDR_CTRL, 24'h000000);
		repeat (60) @(posedge core_clk);
		reg_write(ADDR_DLY, 24'h000110);
		seen.delete();
		slow = 1'b1;
		reg_write(ADDR_CTRL, 24'h000017);
		wait_starts(5);
		for (int i = 0; i < 5; i++)
			check_word({19'h0, seen[i].touch, seen[i].channel}, {19'h0, 1'b0, 4'(1 + i % 2)});
		@(posedge core_clk);
		#1 digital_reset_n = 1'b0;
		repeat (3) @(posedge core_clk);
		#1 digital_reset_n = 1'b1;
		repeat (4) @(posedge core_clk);
		read_check(ADDR_CTRL, 24'h000000);
		read_check(ADDR_DLY, 24'h000000);
		read_check(ADDR_SEL_LO, 24'h000000);
		read_check(ADDR_RES0, 24'h000000);
		check_bit(gp_conv_enable, 1'b0);
		seen.delete();
		repeat (60) @(posedge core_clk);
		check_word(24'(seen.size()), 24'h000000);
		tally_and_finish();
	end
endmodule
